//--- core/mse_regs.vh
// Register indices, field positions, reset values and constants of the metering status block.
`ifndef MSE_REGS_VH
`define MSE_REGS_VH

// Engine word indices; the byte address of a word is four times its index.
`define MSE_IDX_RAW_CURRENT_A 10'h000
`define MSE_IDX_RAW_VOLTAGE_A 10'h001
`define MSE_IDX_RAW_CURRENT_B 10'h002
`define MSE_IDX_RAW_VOLTAGE_B 10'h003
`define MSE_IDX_RAW_CURRENT_C 10'h004
`define MSE_IDX_RAW_VOLTAGE_C 10'h005
`define MSE_IDX_RAW_CURRENT_D 10'h006
`define MSE_IDX_RAW_TEMPERATURE 10'h00A
`define MSE_IDX_RAW_BATTERY 10'h00B
`define MSE_IDX_IDENTITY 10'h00F
`define MSE_IDX_CONFIG 10'h020
`define MSE_IDX_SAG_THRESHOLD 10'h024
`define MSE_IDX_GAIN_ADJUST 10'h040
`define MSE_IDX_STATUS 10'h080

// Status word field positions.
`define MSE_STAT_F0 28
`define MSE_STAT_SAG_C 27
`define MSE_STAT_SAG_B 26
`define MSE_STAT_SAG_A 25

// Configuration word field positions.
`define MSE_CFG_SAG_EN_C 20
`define MSE_CFG_SAG_EN_B 19
`define MSE_CFG_SAG_EN_A 18
`define MSE_CFG_SAG_INT 17
`define MSE_CFG_GAIN_CTRL 16
`define MSE_CFG_SAG_SAMPLE_COUNT_HI 15
`define MSE_CFG_SAG_SAMPLE_COUNT_LO 8
`define MSE_CFG_PHASE_HI 7
`define MSE_CFG_PHASE_LO 6
`define MSE_CFG_PULSE_SRC 5
`define MSE_CFG_SHUNT_C 4
`define MSE_CFG_SHUNT_B 3
`define MSE_CFG_SHUNT_A 2
`define MSE_CFG_PULSE_FAST 1
`define MSE_CFG_PULSE_SLOW 0
`define MSE_CFG_WIDTH 21

// Reset values.
`define MSE_CFG_RESET 21'h005020
`define MSE_SAG_THRESHOLD_RESET 32'h016CAF60
`define MSE_GAIN_RESET 32'h00004000

// Phase select codes.
`define MSE_PHASE_A 2'h0
`define MSE_PHASE_B 2'h1
`define MSE_PHASE_C 2'h2

// Supported meter equation.
`define MSE_EQU_WYE 3'h5

// Fixed point shifts of the gain and temperature arithmetic.
`define MSE_GAIN_FRAC 14
`define MSE_LIN_SHIFT 22
`define MSE_QUAD_SHIFT 30

`endif

//--- core/mse_sag_det.v
// Sag detector for one phase voltage.
`timescale 1ns/100ps
`default_nettype none

module mse_sag_det (
  input wire core_clk,
  input wire rst,
  input wire sample_en,
  input wire [31:0] sample,
  input wire [31:0] threshold,
  input wire [7:0] sample_count,
  input wire enable,
  output reg sag_flag
);

  // Magnitude of the signed sample; the most negative value fits unsigned.
  wire [31:0] mag = sample[31] ? (~sample + 32'h00000001) : sample;
  // Consecutive below-threshold sample counter, saturating at 255.
  reg [7:0] cnt_q;
  wire [7:0] cnt_inc = (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;

  // Each new sample updates the counter and the flag.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      cnt_q <= 8'h00;
      sag_flag <= 1'b0;
    end
    else if (!enable)
    begin
      // Detection off: no count and no flag.
      cnt_q <= 8'h00;
      sag_flag <= 1'b0;
    end
    else if (sample_en)
    begin
      if (mag < threshold)
      begin
        cnt_q <= cnt_inc;
        // The flag sets once the run reaches the programmed count.
        if (cnt_inc >= sample_count)
          sag_flag <= 1'b1;
      end
      else
      begin
        cnt_q <= 8'h00;
        // Of the samples, only one above the threshold clears the flag.
        if (mag > threshold)
          sag_flag <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

//--- core/mse_freq_sq.v
// Fundamental square wave generator from the selected phase voltage.
`timescale 1ns/100ps
`default_nettype none

`include "mse_regs.vh"

module mse_freq_sq (
  input wire core_clk,
  input wire rst,
  input wire sample_en,
  input wire [31:0] volt_a,
  input wire [31:0] volt_b,
  input wire [31:0] volt_c,
  input wire [1:0] phase_sel,
  output reg fundamental_square_wave,
  output reg [31:0] zero_crossing_count
);

  // Selected phase; the forbidden code falls back to phase A.
  reg [31:0] sel_v;

  // Reference phase multiplexer.
  always @*
  begin
    case (phase_sel)
      `MSE_PHASE_B: sel_v = volt_b;
      `MSE_PHASE_C: sel_v = volt_c;
      default: sel_v = volt_a;
    endcase
  end

  // The square wave follows the polarity of the selected voltage, so it
  // toggles exactly twice per fundamental cycle.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      fundamental_square_wave <= 1'b0;
      zero_crossing_count <= 32'h00000000;
    end
    else if (sample_en)
    begin
      fundamental_square_wave <= ~sel_v[31];
      if (fundamental_square_wave == sel_v[31])
        zero_crossing_count <= zero_crossing_count + 32'h00000001;
    end
  end

endmodule
`default_nettype wire

//--- core/mse_engine.v
// Status and configuration words of the metering computation engine.
`timescale 1ns/100ps
`default_nettype none

`include "mse_regs.vh"

module mse_engine #(
  parameter [7:0] DEVICE_IDENTITY_BYTE = 8'hA5, // Arbitrary value.
  parameter [7:0] SILICON_VERSION_BYTE = 8'h01 // Arbitrary value.
) (
  input wire core_clk,
  input wire rst,
  input wire [11:0] mpu_addr,
  input wire mpu_rd,
  input wire mpu_wr,
  input wire [7:0] mpu_wdata,
  output reg [7:0] mpu_rdata,
  output reg mpu_rvalid,
  input wire frame_end,
  input wire [31:0] adc_current_a,
  input wire [31:0] adc_voltage_a,
  input wire [31:0] adc_current_b,
  input wire [31:0] adc_voltage_b,
  input wire [31:0] adc_current_c,
  input wire [31:0] adc_voltage_c,
  input wire [31:0] adc_current_d,
  input wire [31:0] adc_temperature,
  input wire [31:0] adc_battery,
  input wire [2:0] meter_equation_select,
  input wire [31:0] linear_temp_coefficient,
  input wire [31:0] quadratic_temp_coefficient,
  input wire [31:0] temp_difference,
  input wire [31:0] total_real_energy_sum,
  input wire [31:0] total_reactive_energy_sum,
  input wire [31:0] ext_real_pulse_source,
  input wire [31:0] ext_reactive_pulse_source,
  output reg pass_done,
  output reg aux_pulse_output,
  output reg equation_supported,
  output reg [31:0] scaled_current_a,
  output reg [31:0] scaled_voltage_a,
  output reg [31:0] scaled_current_b,
  output reg [31:0] scaled_voltage_b,
  output reg [31:0] scaled_current_c,
  output reg [31:0] scaled_voltage_c,
  output reg [31:0] pulse_real_input,
  output reg [31:0] pulse_reactive_input,
  output wire [31:0] zero_crossing_count
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Scales a sample by the gain word and the optional shunt factor of eight.
  function [31:0] scale_sample;
    input [31:0] sample;
    input [31:0] gain;
    input shunt;
    reg signed [63:0] prod;
    begin
      prod = $signed({{32{sample[31]}}, sample}) * $signed({32'h00000000, gain});
      prod = prod >>> `MSE_GAIN_FRAC;
      if (shunt)
        prod = prod <<< 3;
      scale_sample = prod[31:0];
    end
  endfunction

  // Applies the pulse generator input factor chosen by the speed bits.
  function [31:0] pulse_scale;
    input [31:0] src;
    input fast;
    input slow;
    reg signed [63:0] x3;
    begin
      x3 = $signed({{32{src[31]}}, src}) * 64'sd3;
      case ({fast, slow})
        2'b10: pulse_scale = x3[31:0] << 5;
        2'b01: pulse_scale = x3[36:5];
        default: pulse_scale = x3[31:0] << 1;
      endcase
    end
  endfunction

  // Byte address of an engine word index.
  function [11:0] byte_addr;
    input [9:0] idx;
    begin
      byte_addr = {idx, 2'b00};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Storage.

  // Raw ADC words captured at the end of each multiplexer frame.
  reg [31:0] raw_current_a_q;
  reg [31:0] raw_voltage_a_q;
  reg [31:0] raw_current_b_q;
  reg [31:0] raw_voltage_b_q;
  reg [31:0] raw_current_c_q;
  reg [31:0] raw_voltage_c_q;
  reg [31:0] raw_current_d_q;
  reg [31:0] raw_temperature_q;
  reg [31:0] raw_battery_q;
  // Writable words; reserved configuration bits are not stored.
  reg [`MSE_CFG_WIDTH-1:0] engine_config_word_q;
  reg [31:0] sag_threshold_word_q;
  reg [31:0] gain_adjust_word_q;
  // Status word and pass sequencing.
  reg [31:0] engine_status_word_q;
  reg pass_pend_q;
  // Previous qualified sag flags, for event detection.
  reg [2:0] sag_prev_q;

  // Configuration fields.
  wire [7:0] sag_sample_count = engine_config_word_q[`MSE_CFG_SAG_SAMPLE_COUNT_HI:`MSE_CFG_SAG_SAMPLE_COUNT_LO];
  wire [1:0] phase_select = {engine_config_word_q[`MSE_CFG_PHASE_HI],
    engine_config_word_q[`MSE_CFG_PHASE_LO]};
  wire sag_int_en = engine_config_word_q[`MSE_CFG_SAG_INT];
  wire gain_control_select = engine_config_word_q[`MSE_CFG_GAIN_CTRL];
  wire pulse_source_select = engine_config_word_q[`MSE_CFG_PULSE_SRC];
  wire pulse_fast = engine_config_word_q[`MSE_CFG_PULSE_FAST];
  wire pulse_slow = engine_config_word_q[`MSE_CFG_PULSE_SLOW];

  // Sag flags of the three phases and the square wave.
  wire [2:0] sag_flag;
  wire fundamental_square_wave;

  ////////////////////////////////////////////////////////////////////////////////
  // Sag detection and square wave.

  // Phase A sag detector, fed with the fresh sample of the frame.
  mse_sag_det u_sag_a (
    .core_clk(core_clk),
    .rst(rst),
    .sample_en(frame_end),
    .sample(adc_voltage_a),
    .threshold(sag_threshold_word_q),
    .sample_count(sag_sample_count),
    .enable(engine_config_word_q[`MSE_CFG_SAG_EN_A]),
    .sag_flag(sag_flag[0])
  );

  // Phase B sag detector.
  mse_sag_det u_sag_b (
    .core_clk(core_clk),
    .rst(rst),
    .sample_en(frame_end),
    .sample(adc_voltage_b),
    .threshold(sag_threshold_word_q),
    .sample_count(sag_sample_count),
    .enable(engine_config_word_q[`MSE_CFG_SAG_EN_B]),
    .sag_flag(sag_flag[1])
  );

  // Phase C sag detector.
  mse_sag_det u_sag_c (
    .core_clk(core_clk),
    .rst(rst),
    .sample_en(frame_end),
    .sample(adc_voltage_c),
    .threshold(sag_threshold_word_q),
    .sample_count(sag_sample_count),
    .enable(engine_config_word_q[`MSE_CFG_SAG_EN_C]),
    .sag_flag(sag_flag[2])
  );

  // Square wave and zero crossing count of the reference phase.
  mse_freq_sq u_freq (
    .core_clk(core_clk),
    .rst(rst),
    .sample_en(frame_end),
    .volt_a(adc_voltage_a),
    .volt_b(adc_voltage_b),
    .volt_c(adc_voltage_c),
    .phase_sel(phase_select),
    .fundamental_square_wave(fundamental_square_wave),
    .zero_crossing_count(zero_crossing_count)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Frame capture, pass results and engine-side gain.

  // Internal gain from the temperature coefficients and difference.
  wire signed [63:0] dt = $signed({{32{temp_difference[31]}}, temp_difference});
  wire signed [63:0] lin_term = ($signed({{32{linear_temp_coefficient[31]}},
    linear_temp_coefficient}) * dt) >>> `MSE_LIN_SHIFT;
  wire signed [63:0] quad_term = ((($signed({{32{quadratic_temp_coefficient[31]}},
    quadratic_temp_coefficient}) * dt) >>> `MSE_LIN_SHIFT) * dt) >>> `MSE_QUAD_SHIFT;
  wire signed [63:0] gain_calc = $signed({32'h00000000, `MSE_GAIN_RESET}) + lin_term + quad_term;

  // A frame end captures raw words; the following cycle ends the pass.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      raw_current_a_q <= 32'h00000000;
      raw_voltage_a_q <= 32'h00000000;
      raw_current_b_q <= 32'h00000000;
      raw_voltage_b_q <= 32'h00000000;
      raw_current_c_q <= 32'h00000000;
      raw_voltage_c_q <= 32'h00000000;
      raw_current_d_q <= 32'h00000000;
      raw_temperature_q <= 32'h00000000;
      raw_battery_q <= 32'h00000000;
      pass_pend_q <= 1'b0;
      pass_done <= 1'b0;
      engine_status_word_q <= 32'h00000000;
      sag_prev_q <= 3'h0;
      aux_pulse_output <= 1'b0;
      equation_supported <= 1'b0;
      scaled_current_a <= 32'h00000000;
      scaled_voltage_a <= 32'h00000000;
      scaled_current_b <= 32'h00000000;
      scaled_voltage_b <= 32'h00000000;
      scaled_current_c <= 32'h00000000;
      scaled_voltage_c <= 32'h00000000;
      pulse_real_input <= 32'h00000000;
      pulse_reactive_input <= 32'h00000000;
    end
    else
    begin
      pass_pend_q <= frame_end;
      pass_done <= pass_pend_q;
      equation_supported <= (meter_equation_select == `MSE_EQU_WYE);
      if (frame_end)
      begin
        raw_current_a_q <= adc_current_a;
        raw_voltage_a_q <= adc_voltage_a;
        raw_current_b_q <= adc_current_b;
        raw_voltage_b_q <= adc_voltage_b;
        raw_current_c_q <= adc_current_c;
        raw_voltage_c_q <= adc_voltage_c;
        raw_current_d_q <= adc_current_d;
        raw_temperature_q <= adc_temperature;
        raw_battery_q <= adc_battery;
      end
      if (pass_pend_q)
      begin
        // The whole word is rebuilt from this pass only; unused bits stay zero.
        engine_status_word_q <= {3'b000, fundamental_square_wave, sag_flag, 25'h0000000};
        sag_prev_q <= sag_flag;
        // A pass with any newly set sag flag toggles the auxiliary output once when enabled.
        if (sag_int_en && ((sag_flag & ~sag_prev_q) != 3'h0))
          aux_pulse_output <= ~aux_pulse_output;
        // Each element pairs its own phase voltage and current.
        scaled_current_a <= scale_sample(raw_current_a_q, gain_adjust_word_q,
          engine_config_word_q[`MSE_CFG_SHUNT_A]);
        scaled_voltage_a <= scale_sample(raw_voltage_a_q, gain_adjust_word_q, 1'b0);
        scaled_current_b <= scale_sample(raw_current_b_q, gain_adjust_word_q,
          engine_config_word_q[`MSE_CFG_SHUNT_B]);
        scaled_voltage_b <= scale_sample(raw_voltage_b_q, gain_adjust_word_q, 1'b0);
        scaled_current_c <= scale_sample(raw_current_c_q, gain_adjust_word_q,
          engine_config_word_q[`MSE_CFG_SHUNT_C]);
        scaled_voltage_c <= scale_sample(raw_voltage_c_q, gain_adjust_word_q, 1'b0);
        // Pulse generator source and speed.
        if (pulse_source_select)
        begin
          pulse_real_input <= pulse_scale(ext_real_pulse_source, pulse_fast, pulse_slow);
          pulse_reactive_input <= pulse_scale(ext_reactive_pulse_source, pulse_fast,
            pulse_slow);
        end
        else
        begin
          pulse_real_input <= pulse_scale(total_real_energy_sum, pulse_fast, pulse_slow);
          pulse_reactive_input <= pulse_scale(total_reactive_energy_sum, pulse_fast,
            pulse_slow);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Processor byte port.

  // Byte lane within the word: offset zero is the most significant byte.
  wire [4:0] lane_lsb = {2'b11 - mpu_addr[1:0], 3'b000};
  wire [11:0] word_addr = {mpu_addr[11:2], 2'b00};
  reg [31:0] rd_word;

  // Read multiplexer; unmapped words read as zero.
  always @*
  begin
    case (word_addr)
      byte_addr(`MSE_IDX_RAW_CURRENT_A): rd_word = raw_current_a_q;
      byte_addr(`MSE_IDX_RAW_VOLTAGE_A): rd_word = raw_voltage_a_q;
      byte_addr(`MSE_IDX_RAW_CURRENT_B): rd_word = raw_current_b_q;
      byte_addr(`MSE_IDX_RAW_VOLTAGE_B): rd_word = raw_voltage_b_q;
      byte_addr(`MSE_IDX_RAW_CURRENT_C): rd_word = raw_current_c_q;
      byte_addr(`MSE_IDX_RAW_VOLTAGE_C): rd_word = raw_voltage_c_q;
      byte_addr(`MSE_IDX_RAW_CURRENT_D): rd_word = raw_current_d_q;
      byte_addr(`MSE_IDX_RAW_TEMPERATURE): rd_word = raw_temperature_q;
      byte_addr(`MSE_IDX_RAW_BATTERY): rd_word = raw_battery_q;
      byte_addr(`MSE_IDX_IDENTITY):
        rd_word = {16'h0000, DEVICE_IDENTITY_BYTE, SILICON_VERSION_BYTE};
      byte_addr(`MSE_IDX_CONFIG):
        rd_word = {{(32-`MSE_CFG_WIDTH){1'b0}}, engine_config_word_q};
      byte_addr(`MSE_IDX_SAG_THRESHOLD): rd_word = sag_threshold_word_q;
      byte_addr(`MSE_IDX_GAIN_ADJUST): rd_word = gain_adjust_word_q;
      byte_addr(`MSE_IDX_STATUS): rd_word = engine_status_word_q;
      default: rd_word = 32'h00000000;
    endcase
  end

  // Registered read answer, one cycle after the strobe.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      mpu_rdata <= 8'h00;
      mpu_rvalid <= 1'b0;
    end
    else
    begin
      mpu_rvalid <= mpu_rd;
      if (mpu_rd)
        mpu_rdata <= rd_word[lane_lsb +: 8];
    end
  end

  // Byte writes into the writable words; other addresses ignore writes.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      engine_config_word_q <= `MSE_CFG_RESET;
      sag_threshold_word_q <= `MSE_SAG_THRESHOLD_RESET;
      gain_adjust_word_q <= `MSE_GAIN_RESET;
    end
    else
    begin
      if (mpu_wr && word_addr == byte_addr(`MSE_IDX_CONFIG) && lane_lsb < `MSE_CFG_WIDTH)
      begin
        if (lane_lsb == 5'd16)
          engine_config_word_q[20:16] <= mpu_wdata[4:0];
        else
          engine_config_word_q[lane_lsb +: 8] <= mpu_wdata;
      end
      if (mpu_wr && word_addr == byte_addr(`MSE_IDX_SAG_THRESHOLD))
        sag_threshold_word_q[lane_lsb +: 8] <= mpu_wdata;
      // Gain belongs to the engine unless external control is selected.
      if (!gain_control_select)
      begin
        if (pass_pend_q)
          gain_adjust_word_q <= gain_calc[31:0];
      end
      else if (mpu_wr && word_addr == byte_addr(`MSE_IDX_GAIN_ADJUST))
        gain_adjust_word_q[lane_lsb +: 8] <= mpu_wdata;
    end
  end

endmodule
`default_nettype wire

//--- verification/mse_engine_asserts.sv
// Port checker of the metering status and configuration block.
`timescale 1ns/100ps
`default_nettype none
module mse_engine_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] mpu_addr,
  input wire logic mpu_rd,
  input wire logic [7:0] mpu_rdata,
  input wire logic mpu_rvalid,
  input wire logic frame_end,
  input wire logic [2:0] meter_equation_select,
  input wire logic pass_done,
  input wire logic aux_pulse_output,
  input wire logic equation_supported
);
  // All checks share the core clock and the synchronous reset.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // Each read byte is answered exactly one cycle after its strobe.
  property p_read_answer;
    !$past(rst) |-> mpu_rvalid == $past(mpu_rd);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer timing");
  // A frame end produces the pass pulse two cycles later.
  property p_pass_after_frame;
    frame_end |-> ##2 pass_done;
  endproperty
  a_pass_after_frame: assert property (p_pass_after_frame) else $error("pass missing");
  // No pass pulse appears without a frame end two cycles earlier.
  property p_pass_cause;
    pass_done |-> $past(frame_end, 2);
  endproperty
  a_pass_cause: assert property (p_pass_cause) else $error("pass without frame");
  // Only equation code five is reported as supported.
  property p_equation;
    !$past(rst) |-> equation_supported == ($past(meter_equation_select) == 3'h5);
  endproperty
  a_equation: assert property (p_equation) else $error("equation flag wrong");
  // The sag pulse output moves only at the end of a pass.
  property p_aux_at_pass;
    !$stable(aux_pulse_output) |-> pass_done;
  endproperty
  a_aux_at_pass: assert property (p_aux_at_pass) else $error("aux moved off pass");
  // The three lower status bytes are always zero.
  property p_status_low;
    mpu_rvalid && $past(mpu_addr[11:2]) == 10'h080 && $past(mpu_addr[1:0]) != 2'h0
      |-> mpu_rdata == 8'h00;
  endproperty
  a_status_low: assert property (p_status_low) else $error("status low bits set");
  // The top status byte carries only the square wave and sag flags.
  property p_status_top;
    mpu_rvalid && $past(mpu_addr) == 12'h200 |-> (mpu_rdata & 8'hE1) == 8'h00;
  endproperty
  a_status_top: assert property (p_status_top) else $error("status top bits set");
  // The upper half of the identity word reads zero.
  property p_identity_top;
    mpu_rvalid && $past(mpu_addr[11:1]) == 11'h01E |-> mpu_rdata == 8'h00;
  endproperty
  a_identity_top: assert property (p_identity_top) else $error("identity top set");
endmodule
bind mse_engine mse_engine_asserts chk_u (
  .core_clk(core_clk), .rst(rst), .mpu_addr(mpu_addr), .mpu_rd(mpu_rd),
  .mpu_rdata(mpu_rdata), .mpu_rvalid(mpu_rvalid), .frame_end(frame_end),
  .meter_equation_select(meter_equation_select), .pass_done(pass_done),
  .aux_pulse_output(aux_pulse_output), .equation_supported(equation_supported)
);
`default_nettype wire

//--- verification/mse_mpu_model.sv
// Processor model that moves single bytes across the engine register port.
`timescale 1ns/100ps
`default_nettype none
module mse_mpu_model (
  input wire logic core_clk,
  output logic [11:0] mpu_addr,
  output logic mpu_rd,
  output logic mpu_wr,
  output logic [7:0] mpu_wdata
);
  // The port is idle at time zero.
  initial
  begin
    mpu_addr = 12'h000;
    mpu_rd = 1'b0;
    mpu_wr = 1'b0;
    mpu_wdata = 8'h00;
  end
  // Read one byte; the address is scrambled once released so no stale value helps.
  task automatic rd_byte(input logic [11:0] a);
    @(negedge core_clk);
    mpu_addr = a;
    mpu_rd = 1'b1;
    @(negedge core_clk);
    mpu_rd = 1'b0;
    mpu_addr = ~a;
  endtask
  // Write one byte with a single-cycle strobe.
  task automatic wr_byte(input logic [11:0] a, input logic [7:0] d);
    @(negedge core_clk);
    mpu_addr = a;
    mpu_wdata = d;
    mpu_wr = 1'b1;
    @(negedge core_clk);
    mpu_wr = 1'b0;
    mpu_addr = ~a;
    mpu_wdata = ~d;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench of the metering status and configuration block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [7:0] ID_B = 8'h5A; // Arbitrary value.
  localparam logic [7:0] VER_B = 8'h02; // Arbitrary value.
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] mpu_addr;
  logic mpu_rd, mpu_wr, mpu_rvalid, pass_done, aux_pulse_output, equation_supported;
  logic [7:0] mpu_wdata, mpu_rdata;
  logic frame_end = 1'b0;
  logic [2:0] eq_sel = 3'h5;
  logic [31:0] adc [0:8];
  logic [31:0] misc [0:6];
  logic [11:0] raw_a [0:8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014,
    12'h018, 12'h028, 12'h02C};
  integer seed = 32'h538F;
  integer n_fail = 0;
  integer cmp_count = 0;
  logic [7:0] exp_q [$];
  logic aux_before;
  // Pass results of the pulse, scaling and zero crossing paths.
  logic [31:0] scaled_ia, pulse_real, pulse_reactive, zc, zc_before;
  always #5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  mse_engine #(.DEVICE_IDENTITY_BYTE(ID_B), .SILICON_VERSION_BYTE(VER_B)) dut_u (
    .core_clk(core_clk), .rst(rst), .mpu_addr(mpu_addr), .mpu_rd(mpu_rd), .mpu_wr(mpu_wr),
    .mpu_wdata(mpu_wdata), .mpu_rdata(mpu_rdata), .mpu_rvalid(mpu_rvalid),
    .frame_end(frame_end), .adc_current_a(adc[0]), .adc_voltage_a(adc[1]),
    .adc_current_b(adc[2]), .adc_voltage_b(adc[3]), .adc_current_c(adc[4]),
    .adc_voltage_c(adc[5]), .adc_current_d(adc[6]), .adc_temperature(adc[7]),
    .adc_battery(adc[8]), .meter_equation_select(eq_sel),
    .linear_temp_coefficient(misc[0]), .quadratic_temp_coefficient(misc[1]),
    .temp_difference(misc[2]), .total_real_energy_sum(misc[3]),
    .total_reactive_energy_sum(misc[4]), .ext_real_pulse_source(misc[5]),
    .ext_reactive_pulse_source(misc[6]), .pass_done(pass_done),
    .aux_pulse_output(aux_pulse_output), .equation_supported(equation_supported),
    .scaled_current_a(scaled_ia), .scaled_voltage_a(), .scaled_current_b(),
    .scaled_voltage_b(), .scaled_current_c(), .scaled_voltage_c(),
    .pulse_real_input(pulse_real), .pulse_reactive_input(pulse_reactive),
    .zero_crossing_count(zc)
  );
  mse_mpu_model mpu_u (.core_clk(core_clk), .mpu_addr(mpu_addr), .mpu_rd(mpu_rd),
    .mpu_wr(mpu_wr), .mpu_wdata(mpu_wdata));
  ////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the outcome.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic close_out;
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Queues the four expected bytes of a word, most significant first, and reads them.
  task automatic rd_word(input logic [11:0] a, input logic [31:0] w);
    for (int i = 0; i < 4; i++)
    begin
      exp_q.push_back(w[31-8*i -: 8]);
      mpu_u.rd_byte(a + 12'(i));
    end
  endtask
  // Writes a word as four single bytes, most significant first.
  task automatic wr_word(input logic [11:0] a, input logic [31:0] w);
    for (int i = 0; i < 4; i++)
      mpu_u.wr_byte(a + 12'(i), w[31-8*i -: 8]);
  endtask
  // Presents one frame of random samples, one of them forced when idx is below nine, and waits for the pass.
  task automatic frame(input int idx, input logic [31:0] v);
    int k;
    @(negedge core_clk);
    foreach (adc[i]) adc[i] = $random(seed);
    foreach (misc[i]) misc[i] = $random(seed);
    if (idx < 9) adc[idx] = v;
    frame_end = 1'b1;
    @(negedge core_clk);
    frame_end = 1'b0;
    k = 0;
    while (pass_done !== 1'b1 && k < 8)
    begin
      @(negedge core_clk);
      k++;
    end
    if (pass_done !== 1'b1)
    begin
      n_fail++;
      close_out();
    end
  endtask
  // Takes the oldest queued byte whenever a read answer appears.
  always @(negedge core_clk)
  begin
    if (mpu_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("unasked read", 32'h1, 32'h0);
      else
        check("read byte", {24'h0, mpu_rdata}, {24'h0, exp_q.pop_front()});
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values, raw capture, configuration, sag and phase select.
  initial
  begin
    foreach (adc[i]) adc[i] = 32'h0;
    foreach (misc[i]) misc[i] = 32'h0;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    rd_word(12'h080, 32'h00005020);
    rd_word(12'h090, 32'h016CAF60);
    rd_word(12'h100, 32'h00004000);
    rd_word(12'h03C, {16'h0, ID_B, VER_B});
    rd_word(12'h01C, 32'h0);
    mpu_u.wr_byte(12'h200, 8'hFF);
    rd_word(12'h200, 32'h0);
    for (int e = 0; e < 8; e++)
    begin
      @(negedge core_clk);
      eq_sel = 3'(e);
      repeat (2) @(negedge core_clk);
      check("equation", {31'h0, equation_supported}, {31'h0, e == 5});
    end
    frame(9, 32'h0);
    for (int i = 0; i < 9; i++)
      rd_word(raw_a[i], adc[i]);
    // Sag on A and C with pulse output, count of two, processor-owned gain; top bits dropped.
    wr_word(12'h080, 32'hFFF70220);
    rd_word(12'h080, 32'h00170220);
    wr_word(12'h100, 32'h00002000);
    frame(1, 32'h40000000);
    rd_word(12'h100, 32'h00002000);
    frame(1, 32'h0);
    rd_word(12'h200, 32'h10000000);
    aux_before = aux_pulse_output;
    frame(1, 32'h0);
    rd_word(12'h200, 32'h12000000);
    check("aux toggle", {31'h0, aux_pulse_output}, {31'h0, ~aux_before});
    frame(1, 32'hFE000000);
    rd_word(12'h200, 32'h00000000);
    // Each reference phase drives the square wave; sag detection off.
    mpu_u.wr_byte(12'h081, 8'h01);
    for (int p = 0; p < 3; p++)
    begin
      mpu_u.wr_byte(12'h083, {p[1:0], 6'h20});
      frame(2 * p + 1, 32'h00000005);
      rd_word(12'h200, 32'h10000000);
      frame(2 * p + 1, 32'hFFFFFFFB);
      rd_word(12'h200, 32'h00000000);
    end
    // Shunt on A and fast pulses from the processor values, then slow pulses from the sums.
    zc_before = zc;
    mpu_u.wr_byte(12'h083, 8'h26);
    frame(1, 32'h00000007);
    check("pulse fast", pulse_real, misc[5] * 32'd96);
    check("shunt gain", scaled_ia, ($signed(adc[0]) >>> 1) << 3);
    mpu_u.wr_byte(12'h083, 8'h01);
    frame(1, 32'hFFFFFFF9);
    check("pulse slow", pulse_reactive, 32'((64'($signed(misc[4])) * 64'sd3) >>> 5));
    check("zero crossings", zc, zc_before + 32'h00000002);
    repeat (3) @(negedge core_clk);
    check("pending reads", exp_q.size(), 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
